//--- rtl/cpu_power_save_control.v
`timescale 1ns/1ps
`include "power_save_defines.vh"

// Notes on behaviour
// - Regulator low-power bit picks low-power regulator in Sleep when set.
// - Waking from low-power Sleep adds a regulator settling delay.
// - Normal regulator mode stays active; Sleep exit has no extra delay.
// - Regulator register bit 0 resets to one; software keeps it set.
// - Idle select set: sleep halts CPU and memory, peripherals run.
// - Idle select clear: sleep enters full Sleep, CPU clock stops.
// - Any interrupt ends Idle, even if disabled; idle select unchanged.
// - With recover-on-interrupt and doze, the Idle-ending interrupt gives full speed.
// - Watchdog timeout in Idle wakes, no reset, doze bit unchanged.
// - Clock output, when enabled (active low), keeps running in Idle.
// - Idle/Doze keep oscillator and peripheral clocks; Sleep stops oscillator and instruction clock.
// - Doze active: CPU runs at the ratio; clear: every cycle.
// - Ratio field 000..111 gives 1:2 up to 1:256.
// - Recover-on-interrupt: interrupt entry clears doze active.
// - Doze-on-return: return from ISR sets doze active.
// - Debug forces full speed without changing stored doze active.
// - Doze runs one CPU cycle then idles the rest of the ratio.
// - Interrupt in doze with recover: prefetched instruction at full speed.
module cpu_power_save_control #(
  parameter SETTLE_CYCLES = (`LP_SETTLE_NS + `CLK_PERIOD_NS - 1)
                            / `CLK_PERIOD_NS
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rdata,
  input  wire       sleep_exec,
  input  wire       irq_pending,
  input  wire       isr_entry,
  input  wire       return_from_isr,
  input  wire       wdt_timeout,
  input  wire       in_circuit_debug,
  input  wire       clock_out_enable_n,
  input  wire       osc_ready,
  output reg        cpu_cycle_en,
  output reg        cpu_clk_en,
  output reg        periph_clk_en,
  output reg        osc_clk_en,
  output reg        clock_out_en,
  output reg        regulator_lowpower,
  output reg        wdt_reset_block,
  output reg        wake_pulse,
  output reg        in_idle,
  output reg        in_sleep
);

  // ------------------------------------------------------------
  // Power states
  // ------------------------------------------------------------
  localparam [1:0] ST_RUN    = 2'b00;
  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_SLEEP  = 2'b10;
  localparam [1:0] ST_SETTLE = 2'b11;
  localparam [15:0] SETTLE_N = SETTLE_CYCLES;

  // Doze period length minus one for a ratio code
  function [7:0] doze_last;
    input [2:0] code;
    begin
      doze_last = (8'h02 << code) - 8'h01;
    end
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers for pin-level inputs
  // ------------------------------------------------------------
  reg clkout_meta;
  reg clkout_n_s;
  reg dbg_meta;
  reg dbg_s;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clkout_meta <= 1'b1;
      clkout_n_s  <= 1'b1;
      dbg_meta    <= 1'b0;
      dbg_s       <= 1'b0;
    end else begin
      clkout_meta <= clock_out_enable_n;
      clkout_n_s  <= clkout_meta;
      dbg_meta    <= in_circuit_debug;
      dbg_s       <= dbg_meta;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg        regulator_lowpower_sel;
  reg        regulator_keep;
  reg        idle_select;
  reg        doze_active;
  reg        recover_on_irq;
  reg        doze_on_return;
  reg  [2:0] doze_ratio;
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg [15:0] settle_cnt;
  reg  [7:0] doze_cnt;
  reg        recover_hold;

  wire wr_reg  = wr_en && (addr == `ADDR_REGULATOR);
  wire wr_doze = wr_en && (addr == `ADDR_DOZE_IDLE);
  wire awake   = (state == ST_RUN);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regulator_lowpower_sel <= 1'b0;
      regulator_keep         <= 1'b1;
    end else if (wr_reg) begin
      regulator_lowpower_sel <= wdata[`REG_LOWPOWER_BIT];
      regulator_keep         <= wdata[`REG_KEEP_BIT];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_select    <= 1'b0;
      recover_on_irq <= 1'b0;
      doze_on_return <= 1'b0;
      doze_ratio     <= 3'b000;
    end else if (wr_doze) begin
      idle_select    <= wdata[`DZ_IDLE_SEL_BIT];
      recover_on_irq <= wdata[`DZ_RECOVER_BIT];
      doze_on_return <= wdata[`DZ_ON_RETURN_BIT];
      doze_ratio     <= wdata[`DZ_RATIO_MSB:`DZ_RATIO_LSB];
    end
  end

  // Hardware set/clear of doze active outranks the bus write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      doze_active <= 1'b0;
    end else if (isr_entry && recover_on_irq) begin
      doze_active <= 1'b0;
    end else if (return_from_isr && doze_on_return) begin
      doze_active <= 1'b1;
    end else if (wr_doze) begin
      doze_active <= wdata[`DZ_ACTIVE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Power state machine
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (sleep_exec && !irq_pending)
          next_state = idle_select ? ST_IDLE : ST_SLEEP;
      end
      ST_IDLE: begin
        if (irq_pending || wdt_timeout)
          next_state = ST_RUN;
      end
      ST_SLEEP: begin
        if (irq_pending || wdt_timeout)
          next_state = regulator_lowpower_sel ? ST_SETTLE
                                              : ST_RUN;
      end
      ST_SETTLE: begin
        if (settle_cnt == 16'h0000 && osc_ready)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_RUN;
      settle_cnt <= 16'h0000;
    end else begin
      state <= next_state;
      if (state == ST_SLEEP && next_state == ST_SETTLE)
        settle_cnt <= SETTLE_N - 16'h0001;
      else if (settle_cnt != 16'h0000)
        settle_cnt <= settle_cnt - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Doze cycle gating
  // ------------------------------------------------------------
  wire doze_eff = doze_active && !dbg_s && !recover_hold;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      doze_cnt     <= 8'h00;
      recover_hold <= 1'b0;
    end else begin
      // Pending interrupt with recovery runs the prefetched op at speed
      if (irq_pending && recover_on_irq && doze_active)
        recover_hold <= 1'b1;
      else if (isr_entry || !doze_active)
        recover_hold <= 1'b0;
      if (!doze_eff || !awake || doze_cnt >= doze_last(doze_ratio))
        doze_cnt <= 8'h00;
      else
        doze_cnt <= doze_cnt + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // CPU execution outputs
  // ------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_cycle_en <= 1'b0;
    end else begin
      cpu_cycle_en <= (next_state == ST_RUN) &&
                      (!doze_eff || doze_cnt == 8'h00);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= (next_state == ST_RUN);
    end
  end

  // ------------------------------------------------------------
  // Clock source outputs
  // ------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      periph_clk_en <= 1'b1;
    end else begin
      periph_clk_en <= (next_state != ST_SLEEP) &&
                       (next_state != ST_SETTLE);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_clk_en <= 1'b1;
    end else begin
      osc_clk_en <= (next_state != ST_SLEEP);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_out_en <= 1'b0;
    end else begin
      clock_out_en <= !clkout_n_s &&
                      (next_state != ST_SLEEP);
    end
  end

  // ------------------------------------------------------------
  // Regulator and watchdog outputs
  // ------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regulator_lowpower <= 1'b0;
    end else begin
      regulator_lowpower <= (next_state == ST_SLEEP) &&
                            regulator_lowpower_sel;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_reset_block <= 1'b0;
    end else begin
      wdt_reset_block <= (next_state == ST_IDLE);
    end
  end

  // ------------------------------------------------------------
  // Power state outputs
  // ------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= !awake && (next_state == ST_RUN);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_idle <= 1'b0;
    end else begin
      in_idle <= (next_state == ST_IDLE);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_sleep <= 1'b0;
    end else begin
      in_sleep <= (next_state == ST_SLEEP) ||
                  (next_state == ST_SETTLE);
    end
  end

  // ------------------------------------------------------------
  // Read-back
  // ------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= `ZERO8;
    end else begin
      if (rd_en) begin
        case (addr)
          `ADDR_REGULATOR:
            rdata <= {6'b000000, regulator_lowpower_sel,
                      regulator_keep} & `REGULATOR_MASK;
          `ADDR_DOZE_IDLE:
            rdata <= {idle_select, doze_active, recover_on_irq,
                      doze_on_return, 1'b0, doze_ratio}
                     & `DOZE_IDLE_MASK;
          `ADDR_STATUS:
            rdata <= {4'b0000, doze_eff, in_sleep, in_idle,
                      cpu_cycle_en};
          default: rdata <= `ZERO8;
        endcase
      end else begin
        rdata <= `ZERO8;
      end
    end
  end

endmodule

//--- rtl/power_save_defines.vh
`ifndef POWER_SAVE_DEFINES_VH
`define POWER_SAVE_DEFINES_VH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define ADDR_W              4
`define ADDR_REGULATOR      4'h0
`define ADDR_DOZE_IDLE      4'h1
`define ADDR_STATUS         4'h2

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define REG_KEEP_BIT        0
`define REG_LOWPOWER_BIT    1
`define DZ_RATIO_LSB        0
`define DZ_RATIO_MSB        2
`define DZ_ON_RETURN_BIT    4
`define DZ_RECOVER_BIT      5
`define DZ_ACTIVE_BIT       6
`define DZ_IDLE_SEL_BIT     7

// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define REGULATOR_RESET     8'h01
`define REGULATOR_MASK      8'h03
`define DOZE_IDLE_RESET     8'h00
`define DOZE_IDLE_MASK      8'hF7
`define ZERO8               8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS       50
`define LP_SETTLE_NS        2000
`define WAKE_READY_W        8

`endif

//--- tb/power_save_chk.sv
`timescale 1ns/1ps
module power_save_chk #(
  parameter SETTLE_CYCLES = 40
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       irq_pending,
  input wire logic       wdt_timeout,
  input wire logic       in_circuit_debug,
  input wire logic       clock_out_enable_n,
  input wire logic       cpu_cycle_en,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_clk_en,
  input wire logic       clock_out_en,
  input wire logic       regulator_lowpower,
  input wire logic       wdt_reset_block,
  input wire logic       wake_pulse,
  input wire logic       in_idle,
  input wire logic       in_sleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // Multi-step conditions
  // ------------------------------------------------------------
  sequence s_dbg_held;
    in_circuit_debug [*4] ##0 (!in_idle && !in_sleep) [*2];
  endsequence
  sequence s_clkout_idle;
    !clock_out_enable_n [*4] ##0 in_idle;
  endsequence
  AST_IDLE_CLOCKS: assert property (in_idle |-> !cpu_clk_en && !cpu_cycle_en
    && periph_clk_en && osc_clk_en) else $error("idle clock gating wrong");
  AST_IDLE_IRQ: assert property (in_idle && irq_pending |=>
    !in_idle && wake_pulse) else $error("interrupt did not end idle");
  AST_IDLE_WDT: assert property (in_idle |-> wdt_reset_block)
    else $error("watchdog reset not blocked in idle");
  AST_WDT_WAKE: assert property (in_idle && wdt_timeout |=> !in_idle)
    else $error("watchdog did not wake idle");
  AST_SLEEP_STOP: assert property ($rose(in_sleep) |-> !osc_clk_en
    && !cpu_clk_en) else $error("clocks running in sleep");
  AST_LP_SLEEP: assert property (regulator_lowpower |-> in_sleep)
    else $error("low-power regulator outside sleep");
  AST_CLKOUT: assert property (s_clkout_idle |-> clock_out_en)
    else $error("clock output stopped in idle");
  AST_DEBUG: assert property (s_dbg_held |-> cpu_cycle_en)
    else $error("debug not at full speed");
  AST_WAKE_ONE: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  AST_RD_IDLE: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data without read");
endmodule
bind cpu_power_save_control power_save_chk #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (.*);

//--- tb/cpu_power_save_control_tb.sv
`timescale 1ns/1ps
`include "power_save_defines.vh"
module cpu_power_save_control_tb;
  localparam int SC = 3;
  logic clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, sleep_exec = 0;
  logic irq_pending = 0, isr_entry = 0, return_from_isr = 0;
  logic wdt_timeout = 0, in_circuit_debug = 0, clock_out_enable_n = 0;
  logic osc_ready = 1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  wire [7:0] rdata;
  wire cpu_cycle_en, cpu_clk_en, periph_clk_en, osc_clk_en, clock_out_en;
  wire regulator_lowpower, wdt_reset_block, wake_pulse, in_idle, in_sleep;
  int num_errors = 0, checks_done = 0, cyc = 0, c, n, n0, n1;
  logic [7:0] tw [4] = '{8'h61, 8'h41, 8'h11, 8'h01};
  logic [7:0] te [4] = '{8'h21, 8'h41, 8'h51, 8'h01};
  always #25 clk = ~clk;
  cpu_power_save_control #(.SETTLE_CYCLES(SC)) u_dut (.*);
  // ------------------------------------------------------------
  // Access and check tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1;
    @(posedge clk);
    wr_en <= 0;
    @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1;
    @(posedge clk);
    rd_en <= 0;
    @(negedge clk);
    chk("rdata", rdata, e);
    @(posedge clk);
  endtask
  task cnt(input int k, output int r);
    r = 0;
    repeat (k) begin
      @(negedge clk);
      r += (cpu_cycle_en === 1'b1);
    end
    @(posedge clk);
  endtask
  task go_sleep;
    sleep_exec <= 1;
    @(posedge clk);
    sleep_exec <= 0;
    repeat (3) @(posedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
    rd(`ADDR_REGULATOR, 8'h01);
    rd(`ADDR_DOZE_IDLE, 8'h00);
    wr(`ADDR_REGULATOR, 8'hFF);
    rd(`ADDR_REGULATOR, 8'h03);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    rd(`ADDR_STATUS, 8'h01);
    $display("registers done");
    for (int r = 0; r < 8; r++) begin
      wr(`ADDR_DOZE_IDLE, 8'h00);
      wr(`ADDR_DOZE_IDLE, 8'h40 | r[7:0]);
      repeat (2 << r) @(posedge clk);
      cnt(4 << r, c);
      chk("doze_cycles", c[7:0], 8'h02);
    end
    wr(`ADDR_DOZE_IDLE, 8'h00);
    cnt(8, c);
    chk("full_cycles", c[7:0], 8'h08);
    $display("doze done");
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_DOZE_IDLE, tw[i]);
      addr <= `ADDR_DOZE_IDLE;
      wdata <= tw[i];
      wr_en <= 1;
      isr_entry <= (i < 2);
      return_from_isr <= (i >= 2);
      @(posedge clk);
      wr_en <= 0;
      isr_entry <= 0;
      return_from_isr <= 0;
      @(posedge clk);
      rd(`ADDR_DOZE_IDLE, te[i]);
    end
    $display("irq entry done");
    wr(`ADDR_DOZE_IDLE, 8'hE1);
    go_sleep;
    @(negedge clk);
    chk("in_idle", in_idle, 8'h01);
    chk("clock_out_en", clock_out_en, 8'h01);
    chk("periph_clk_en", periph_clk_en, 8'h01);
    chk("cpu_clk_en", cpu_clk_en, 8'h00);
    chk("wdt_reset_block", wdt_reset_block, 8'h01);
    @(posedge clk);
    irq_pending <= 1;
    repeat (2) @(posedge clk);
    cnt(4, c);
    chk("recover_cycles", c[7:0], 8'h04);
    chk("in_idle", in_idle, 8'h00);
    isr_entry <= 1;
    irq_pending <= 0;
    @(posedge clk);
    isr_entry <= 0;
    rd(`ADDR_DOZE_IDLE, 8'hA1);
    wr(`ADDR_DOZE_IDLE, 8'hE1);
    go_sleep;
    wdt_timeout <= 1;
    @(posedge clk);
    wdt_timeout <= 0;
    repeat (2) @(posedge clk);
    chk("in_idle", in_idle, 8'h00);
    rd(`ADDR_DOZE_IDLE, 8'hE1);
    $display("idle done");
    for (int m = 0; m < 2; m++) begin
      wr(`ADDR_REGULATOR, m ? 8'h03 : 8'h01);
      wr(`ADDR_DOZE_IDLE, 8'h00);
      go_sleep;
      @(negedge clk);
      chk("in_sleep", in_sleep, 8'h01);
      chk("reg_lowpower", regulator_lowpower, m[7:0]);
      chk("osc_clk_en", osc_clk_en, 8'h00);
      @(posedge clk);
      irq_pending <= 1;
      n = 0;
      while (in_sleep !== 1'b0 && n < 200) begin
        @(negedge clk);
        n++;
      end
      @(posedge clk);
      irq_pending <= 0;
      if (m == 1) n1 = n;
      else n0 = n;
    end
    chk("settle_delay", n1 >= n0 + SC, 8'h01);
    chk("wake_normal", n0[7:0], 8'h02);
    $display("sleep done");
    wr(`ADDR_DOZE_IDLE, 8'h47);
    in_circuit_debug <= 1;
    repeat (4) @(posedge clk);
    cnt(8, c);
    chk("debug_cycles", c[7:0], 8'h08);
    in_circuit_debug <= 0;
    rd(`ADDR_DOZE_IDLE, 8'h47);
    $display("debug done");
    end_of_test;
  end
endmodule
